/* inc/scd_mem_if.sv */
// Write and registered-read port of a small decoder memory
`timescale 1ns/10ps
interface scd_mem_if #(
    parameter int W = 1,
    parameter int D = 432
);
    localparam int AW = $clog2(D);
    logic          we;
    logic [AW-1:0] waddr;
    logic [W-1:0]  wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0]  rdata;
    modport user (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* inc/scd_pkg.sv */
// Constants and types shared by the speech channel decoder files
package scd_pkg;

    // Block sizes, type-1 bits per block
    localparam logic [8:0] IN_LEN_NORM   = 9'h1B0;
    localparam logic [8:0] IN_LEN_STEAL  = 9'h0D8;
    // Least sensitive class, passed through
    localparam logic [8:0] C0_LEN_NORM   = 9'h066;
    localparam logic [8:0] C0_LEN_STEAL  = 9'h033;
    // Received class 1 bits at rate 2/3
    localparam logic [9:0] C1_RX_NORM    = 10'h0A8;
    localparam logic [9:0] C1_RX_STEAL   = 10'h054;
    // Type-3 totals per block
    localparam logic [8:0] T3_LEN_NORM   = 9'h11E;
    localparam logic [8:0] T3_LEN_STEAL  = 9'h091;

    // Trellis length: every type-3 bit past class 0
    localparam logic [7:0] TRL_NORM      = 8'(T3_LEN_NORM - C0_LEN_NORM);
    localparam logic [7:0] TRL_STEAL     = 8'(T3_LEN_STEAL - C0_LEN_STEAL);
    // Mother-code positions of class 1: three per type-3 bit, rate 2/3
    localparam logic [9:0] C1_DEP_NORM   = 10'(C1_RX_NORM * 2);
    localparam logic [9:0] C1_DEP_STEAL  = 10'(C1_RX_STEAL * 2);
    localparam logic [9:0] C2_DEP_NORM   = 10'((TRL_NORM - C1_RX_NORM * 2 / 3) * 3);
    localparam logic [9:0] C2_DEP_STEAL  = 10'((TRL_STEAL - C1_RX_STEAL * 2 / 3) * 3);

    // Matrix de-interleaver geometry
    localparam logic [4:0] DI_ROWS       = 5'h12;
    localparam logic [4:0] DI_COLS       = 5'h18;

    // Puncturing periods and kept-position masks (bit i set keeps position i of the period)
    localparam logic [4:0]  PER_R23      = 5'h06;
    localparam logic [4:0]  PER_R818     = 5'h0C;
    localparam logic [4:0]  PER_R817     = 5'h18;
    localparam logic [23:0] MASK_R23     = 24'h00000B;
    localparam logic [23:0] MASK_R818    = 24'h0006DF;
    localparam logic [23:0] MASK_R817    = 24'h6DB6DF;

    // Check code layout
    localparam logic [7:0] TAIL_LEN      = 8'h04;
    localparam logic [7:0] PAR_NORM      = 8'h08;
    localparam logic [7:0] PAR_STEAL     = 8'h04;
    localparam logic [7:0] MSC_NORM      = 8'h48;
    localparam logic [7:0] MSC_STEAL     = 8'h26;
    localparam logic [6:0] CRC_G_NORM    = 7'h09;
    localparam logic [6:0] CRC_G_STEAL   = 7'h03;
    localparam logic [6:0] CRC_W_NORM    = 7'h7F;
    localparam logic [6:0] CRC_W_STEAL   = 7'h0F;

    // Viterbi
    localparam int         NSTATES       = 16;
    localparam int         PM_W          = 10;
    localparam logic [9:0] PM_INIT       = 10'h080;
    localparam int         SURV_DEPTH    = 184;
    localparam int         IN_DEPTH      = 432;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LOAD  = 3'h1,
        ST_PASS  = 3'h3,
        ST_FETCH = 3'h2,
        ST_ACS   = 3'h6,
        ST_TRACE = 3'h7,
        ST_EMIT  = 3'h5,
        ST_DONE  = 3'h4
    } scd_state_e;

endpackage

/* logic/scd_decoder.sv */
// Receive-side speech channel decoder: de-interleave, de-puncture, Viterbi, check
`timescale 1ns/10ps
// Contract
// - Rebuild mother block, gaps filled with zero
// - Kept positions follow period and coefficient list
// - Viterbi decode 16-state rate 1/3 code
// - Bad-frame flag set on any parity mismatch
// - Parity is systematic division remainder
// - Output classes without parity and tail
// - Normal mode takes 432-bit slot block
// - Normal mode de-interleaves 18 by 24 transpose
// - Normal first 102 bits pass undecoded
// - Normal 168 at 2/3, 162 at 8/18
// - Rate 2/3 keeps 1,2,4 of 6
// - Rate 8/18 nine coefficients, period 12
// - Normal check: 72 bits, 1+X^3+X^7
// - Normal eighth bit is overall parity
// - Stealing mode takes 216-bit half slot
// - Stealing mode uses signalling steal permutation
// - Stealing first 51 bits pass undecoded
// - Stealing 84 at 2/3, 81 at 8/17
// - Rate 8/17 seventeen coefficients, period 24
// - Stealing check: 38 bits, 1+X+X^4
module scd_decoder
    import scd_pkg::*;
#(
    parameter logic [8:0] STEAL_STRIDE = 9'h005
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic in_bit_in,
    input  wire logic in_valid_in,
    input  wire logic in_steal_in,
    output logic      in_ready_out,
    output logic      out_bit_out,
    output logic      out_valid_out,
    output logic      out_done_out,
    output logic      out_bfi_out
);
    scd_state_e            state_q;
    logic                  steal_q;
    logic [8:0]            cnt_q;
    logic                  ph_q;
    logic [4:0]            row_q;
    logic [4:0]            col_q;
    logic [8:0]            rd_ptr_q;
    logic [9:0]            pos_q;
    logic [4:0]            per_q;
    logic                  cls2_q;
    logic [1:0]            sidx_q;
    logic [2:0]            sym_bit_q;
    logic [2:0]            sym_val_q;
    logic [7:0]            step_q;
    logic [PM_W-1:0]       pm_q [NSTATES];
    logic [PM_W-1:0]       pm_d [NSTATES];
    logic [NSTATES-1:0]    dec_w;
    logic [3:0]            tb_q;
    logic [SURV_DEPTH-1:0] dec_q;
    logic [6:0]            crc_q;
    logic                  ov_q;
    logic [7:0]            par_q;
    logic                  out_bit_q;
    logic                  out_valid_q;
    logic                  done_q;
    logic                  bfi_q;

    scd_mem_if #(.W(1), .D(IN_DEPTH))         in_if ();
    scd_mem_if #(.W(NSTATES), .D(SURV_DEPTH)) sv_if ();

    scd_mem #(.W(1), .D(IN_DEPTH)) u_in_mem (
        .clk_in (clk_in),
        .mem_if (in_if.mem)
    );
    scd_mem #(.W(NSTATES), .D(SURV_DEPTH)) u_sv_mem (
        .clk_in (clk_in),
        .mem_if (sv_if.mem)
    );

    // Mode-dependent selections
    wire logic [8:0]  blk_len  = steal_q ? IN_LEN_STEAL : IN_LEN_NORM;
    wire logic [8:0]  c0_len   = steal_q ? C0_LEN_STEAL : C0_LEN_NORM;
    wire logic [7:0]  trl_len  = steal_q ? TRL_STEAL : TRL_NORM;
    wire logic [9:0]  c1_dep   = steal_q ? C1_DEP_STEAL : C1_DEP_NORM;
    wire logic [9:0]  c2_dep   = steal_q ? C2_DEP_STEAL : C2_DEP_NORM;
    wire logic [7:0]  par_len  = steal_q ? PAR_STEAL : PAR_NORM;
    wire logic [7:0]  msc_len  = steal_q ? MSC_STEAL : MSC_NORM;
    wire logic [7:0]  par_lo   = 8'(trl_len - TAIL_LEN - par_len);
    wire logic [7:0]  msc_lo   = 8'(par_lo - msc_len);
    wire logic [4:0]  per_len  = !cls2_q ? PER_R23 : (steal_q ? PER_R817 : PER_R818);
    wire logic [23:0] punc_msk = !cls2_q ? MASK_R23
                               : (steal_q ? MASK_R817 : MASK_R818);
    wire logic [9:0]  cls_end  = cls2_q ? c2_dep : c1_dep;
    wire logic        hit      = punc_msk[per_q];
    wire logic [9:0]  pos_nxt  = pos_q + 10'h001;
    wire logic [4:0]  per_nxt  = (per_q + 5'h01 == per_len) ? 5'h00 : per_q + 5'h01;

    // Type-2 to type-1 address walk
    wire logic        row_last = (row_q == DI_ROWS - 5'h01);
    wire logic [8:0]  ptr_norm = row_last ? {4'h0, col_q + 5'h01}
                                          : rd_ptr_q + {4'h0, DI_COLS};
    wire logic [9:0]  ptr_sum  = {1'b0, rd_ptr_q} + {1'b0, STEAL_STRIDE};
    wire logic [8:0]  ptr_stl  = (ptr_sum >= {1'b0, IN_LEN_STEAL})
                               ? 9'(ptr_sum - {1'b0, IN_LEN_STEAL}) : ptr_sum[8:0];
    wire logic [8:0]  ptr_nxt  = steal_q ? ptr_stl : ptr_norm;

    // Traceback: decoded bit and check-code position
    wire logic        tb_bit   = tb_q[3];
    wire logic        tb_dec   = sv_if.rdata[tb_q];
    wire logic        in_msc   = (step_q >= msc_lo) && (step_q < par_lo);
    wire logic        in_par   = (step_q >= par_lo) && (step_q < par_lo + par_len);
    wire logic [2:0]  par_idx  = 3'(step_q - par_lo);
    wire logic        crc_fb   = tb_bit ^ (steal_q ? crc_q[3] : crc_q[6]);
    wire logic [6:0]  crc_sh   = {crc_q[5:0], 1'b0} & (steal_q ? CRC_W_STEAL : CRC_W_NORM);
    wire logic [6:0]  crc_gen  = steal_q ? CRC_G_STEAL : CRC_G_NORM;
    wire logic [6:0]  crc_nxt  = crc_sh ^ (crc_fb ? crc_gen : 7'h00);
    wire logic        ov_full  = ov_q ^ (^crc_q);
    wire logic        bfi_norm = (par_q[6:0] != crc_q) || (par_q[7] != ov_full);
    wire logic        bfi_stl  = (par_q[3:0] != crc_q[3:0]);
    wire logic        bfi_calc = steal_q ? bfi_stl : bfi_norm;

    // Expected mother-code outputs from a previous state and input bit
    function automatic logic [2:0] enc_out(input logic [3:0] s, input logic u);
        enc_out[0] = u ^ s[3] ^ s[2] ^ s[1] ^ s[0];
        enc_out[1] = u ^ s[3] ^ s[1] ^ s[0];
        enc_out[2] = u ^ s[2] ^ s[0];
    endfunction

    // Hamming distance over kept positions; erased ones cost nothing
    function automatic logic [PM_W-1:0] br_met(input logic [2:0] e,
                                               input logic [2:0] b,
                                               input logic [2:0] v);
        logic [2:0] mis;
        mis = (e ^ b) & v;
        br_met = PM_W'(mis[0]) + PM_W'(mis[1]) + PM_W'(mis[2]);
    endfunction

    // Add-compare-select, one butterfly leg per next state
    for (genvar n = 0; n < NSTATES; n++) begin : g_acs
        localparam logic [3:0] NS = 4'(n);
        wire logic [3:0]      p0 = {NS[2:0], 1'b0};
        wire logic [3:0]      p1 = {NS[2:0], 1'b1};
        wire logic [PM_W-1:0] c0 = pm_q[p0] + br_met(enc_out(p0, NS[3]), sym_bit_q, sym_val_q);
        wire logic [PM_W-1:0] c1 = pm_q[p1] + br_met(enc_out(p1, NS[3]), sym_bit_q, sym_val_q);
        assign dec_w[n] = (c1 < c0);
        assign pm_d[n]  = (c1 < c0) ? c1 : c0;
    end

    assign in_ready_out   = (state_q == ST_IDLE) || (state_q == ST_LOAD);
    assign in_if.we       = in_ready_out && in_valid_in;
    assign in_if.waddr    = (state_q == ST_IDLE) ? 9'h000 : cnt_q;
    assign in_if.wdata    = in_bit_in;
    assign in_if.raddr    = rd_ptr_q;
    assign sv_if.we       = (state_q == ST_ACS);
    assign sv_if.waddr    = step_q;
    assign sv_if.wdata    = dec_w;
    assign sv_if.raddr    = step_q;
    assign out_bit_out    = out_bit_q;
    assign out_valid_out  = out_valid_q;
    assign out_done_out   = done_q;
    assign out_bfi_out    = bfi_q;

    // Path metrics; the start state is favoured since the encoder starts cleared
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int s = 0; s < NSTATES; s++) begin
                pm_q[s] <= '0;
            end
        end else if (state_q == ST_IDLE) begin
            for (int s = 0; s < NSTATES; s++) begin
                pm_q[s] <= (s == 0) ? '0 : PM_INIT;
            end
        end else if (state_q == ST_ACS) begin
            pm_q <= pm_d;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q     <= ST_IDLE;
            steal_q     <= 1'b0;
            cnt_q       <= '0;
            ph_q        <= 1'b0;
            row_q       <= '0;
            col_q       <= '0;
            rd_ptr_q    <= '0;
            pos_q       <= '0;
            per_q       <= '0;
            cls2_q      <= 1'b0;
            sidx_q      <= '0;
            sym_bit_q   <= '0;
            sym_val_q   <= '0;
            step_q      <= '0;
            tb_q        <= '0;
            dec_q       <= '0;
            crc_q       <= '0;
            ov_q        <= 1'b0;
            par_q       <= '0;
            out_bit_q   <= 1'b0;
            out_valid_q <= 1'b0;
            done_q      <= 1'b0;
            bfi_q       <= 1'b0;
        end else begin
            out_valid_q <= 1'b0;
            done_q      <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    pos_q  <= '0;
                    per_q  <= '0;
                    cls2_q <= 1'b0;
                    sidx_q <= '0;
                    step_q <= '0;
                    crc_q  <= '0;
                    ov_q   <= 1'b0;
                    par_q  <= '0;
                    ph_q   <= 1'b0;
                    if (in_valid_in) begin
                        steal_q <= in_steal_in;
                        cnt_q   <= 9'h001;
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (in_valid_in) begin
                        cnt_q <= cnt_q + 9'h001;
                        if (cnt_q == blk_len - 9'h001) begin
                            cnt_q    <= '0;
                            row_q    <= '0;
                            col_q    <= '0;
                            rd_ptr_q <= steal_q ? STEAL_STRIDE : 9'h000;
                            state_q  <= ST_PASS;
                        end
                    end
                end
                ST_PASS: begin
                    // Registered read: address in phase 0, data in phase 1
                    ph_q <= ~ph_q;
                    if (ph_q) begin
                        out_bit_q   <= in_if.rdata;
                        out_valid_q <= 1'b1;
                        rd_ptr_q    <= ptr_nxt;
                        row_q       <= row_last ? 5'h00 : row_q + 5'h01;
                        col_q       <= row_last ? col_q + 5'h01 : col_q;
                        cnt_q       <= cnt_q + 9'h001;
                        if (cnt_q == c0_len - 9'h001) begin
                            state_q <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    ph_q <= ~ph_q;
                    if (ph_q) begin
                        sym_bit_q[sidx_q] <= hit ? in_if.rdata : 1'b0;
                        sym_val_q[sidx_q] <= hit;
                        if (hit) begin
                            rd_ptr_q <= ptr_nxt;
                            row_q    <= row_last ? 5'h00 : row_q + 5'h01;
                            col_q    <= row_last ? col_q + 5'h01 : col_q;
                        end
                        if (pos_nxt == cls_end && !cls2_q) begin
                            pos_q  <= '0;
                            per_q  <= '0;
                            cls2_q <= 1'b1;
                        end else begin
                            pos_q <= pos_nxt;
                            per_q <= per_nxt;
                        end
                        if (sidx_q == 2'h2) begin
                            sidx_q  <= '0;
                            state_q <= ST_ACS;
                        end else begin
                            sidx_q <= sidx_q + 2'h1;
                        end
                    end
                end
                ST_ACS: begin
                    ph_q <= 1'b0;
                    if (step_q == trl_len - 8'h01) begin
                        tb_q    <= '0;
                        state_q <= ST_TRACE;
                    end else begin
                        step_q  <= step_q + 8'h01;
                        state_q <= ST_FETCH;
                    end
                end
                ST_TRACE: begin
                    // Walks newest first, so the check bits meet the divider top-down
                    ph_q <= ~ph_q;
                    if (ph_q) begin
                        dec_q[step_q] <= tb_bit;
                        tb_q          <= {tb_q[2:0], tb_dec};
                        if (in_msc) begin
                            crc_q <= crc_nxt;
                            ov_q  <= ov_q ^ tb_bit;
                        end
                        if (in_par) begin
                            par_q[par_idx] <= tb_bit;
                        end
                        if (step_q == 8'h00) begin
                            cnt_q   <= '0;
                            state_q <= ST_EMIT;
                        end else begin
                            step_q <= step_q - 8'h01;
                        end
                    end
                end
                ST_EMIT: begin
                    out_bit_q   <= dec_q[cnt_q[7:0]];
                    out_valid_q <= 1'b1;
                    cnt_q       <= cnt_q + 9'h001;
                    if (cnt_q[7:0] == par_lo - 8'h01) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    bfi_q   <= bfi_calc;
                    done_q  <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* logic/scd_mem.sv */
// Simple dual-port memory with registered read data
`timescale 1ns/10ps
module scd_mem #(
    parameter int W = 1,
    parameter int D = 432
) (
    input wire logic clk_in,
    scd_mem_if.mem   mem_if
);
    logic [W-1:0] store [D];
    logic [W-1:0] rdata_q;

    always_ff @(posedge clk_in) begin
        if (mem_if.we) begin
            store[mem_if.waddr] <= mem_if.wdata;
        end
        rdata_q <= store[mem_if.raddr];
    end

    assign mem_if.rdata = rdata_q;
endmodule

/* verif/scd_decoder_properties.sv */
// Port-level checks of the speech channel decoder
`timescale 1ns/10ps
module scd_decoder_properties (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    input wire logic in_steal_in,
    input wire logic in_ready_out,
    input wire logic out_valid_out,
    input wire logic out_done_out,
    input wire logic out_bfi_out
);
    logic [8:0]      in_cnt_q;
    logic [8:0]      out_cnt_q;
    logic            mode_q;
    wire logic       take  = in_valid_in && in_ready_out;
    wire logic [8:0] c0_w  = mode_q ? 9'h033 : 9'h066;
    wire logic [8:0] blk_w = mode_q ? 9'h0D8 : 9'h1B0;
    wire logic [8:0] out_w = mode_q ? 9'h089 : 9'h112;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Mode is latched only with the first bit, as the decoder does
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            in_cnt_q  <= 9'h000;
            out_cnt_q <= 9'h000;
            mode_q    <= 1'b0;
        end else begin
            // Ready is back during the done cycle, so a first bit may be taken there
            in_cnt_q  <= out_done_out ? 9'(take) : in_cnt_q + 9'(take);
            out_cnt_q <= out_done_out ? 9'h000 : out_cnt_q + 9'(out_valid_out);
            if (take && (in_cnt_q == 9'h000 || out_done_out)) begin
                mode_q <= in_steal_in;
            end
        end
    end

    sequence gap_bit_s;
        !out_valid_out ##1 out_valid_out;
    endsequence
    sequence idle8_s;
        !out_valid_out [*8];
    endsequence

    load_count_a: assert property (
        $fell(in_ready_out) |-> in_cnt_q == blk_w) else $error("block length wrong");
    out_count_a: assert property (
        out_done_out |-> out_cnt_q == out_w) else $error("output bit count wrong");
    class0_pace_a: assert property (
        out_valid_out && out_cnt_q < c0_w - 9'h001 |=> gap_bit_s)
        else $error("class 0 pacing wrong");
    decode_gap_a: assert property (
        out_valid_out && out_cnt_q == c0_w - 9'h001 |=> idle8_s)
        else $error("no decode gap after class 0");
    quiet_load_a: assert property (
        in_ready_out |-> !out_valid_out && !(out_done_out && $past(in_ready_out)))
        else $error("output while loading");
    ready_return_a: assert property (
        out_done_out |=> in_ready_out && !out_done_out) else $error("ready not back after done");
    bfi_hold_a: assert property (
        !out_done_out |-> $stable(out_bfi_out)) else $error("flag moved without done");
    done_after_a: assert property (
        out_done_out |-> $past(out_valid_out) && !out_valid_out) else $error("done misplaced");
    first_out_a: assert property (
        $fell(in_ready_out) |-> ##[1:4] out_valid_out) else $error("class 0 late");
    bad_frame_c: cover property (out_done_out && out_bfi_out);
endmodule

bind scd_decoder scd_decoder_properties u_props (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (in_valid_in),
    .in_steal_in   (in_steal_in),
    .in_ready_out  (in_ready_out),
    .out_valid_out (out_valid_out),
    .out_done_out  (out_done_out),
    .out_bfi_out   (out_bfi_out)
);

/* verif/scd_peer.sv */
// Demodulator-side encoder and speech-side sink around the decoder
`timescale 1ns/10ps
module scd_peer #(
    parameter int STRIDE = 5
) (
    input  wire logic clk_in,
    input  wire logic in_ready_in,
    input  wire logic out_bit_in,
    input  wire logic out_valid_in,
    input  wire logic out_done_in,
    input  wire logic out_bfi_in,
    output logic      bit_out,
    output logic      valid_out,
    output logic      steal_out
);
    logic got[$];
    logic exp_q[$];
    logic bfi_q;
    logic done_seen;
    logic u[0:183];
    logic v[0:551];
    logic c2[0:431];
    logic tx[0:431];

    initial begin
        bit_out   = 1'b0;
        valid_out = 1'b0;
        steal_out = 1'b0;
        bfi_q     = 1'b0;
        done_seen = 1'b0;
    end

    always @(posedge clk_in) begin
        if (out_valid_in === 1'b1) got.push_back(out_bit_in);
        if (out_done_in === 1'b1) begin
            bfi_q     <= out_bfi_in;
            done_seen <= 1'b1;
        end
    end

    // Encode a block, corrupt on request, stream it, wait for the result
    task automatic send(input logic st, input int pat, input int bad,
                        input int f0, input int f1, input int gap);
        int n, c0, l, p, msc, c1t, base, k, j, i;
        logic [6:0]  r;
        logic [3:0]  s;
        logic [23:0] msk;
        logic        fb;
        logic        op;
        n = st ? 216 : 432;
        c0 = st ? 51 : 102;
        l = st ? 94 : 184;
        p = st ? 4 : 8;
        msc = st ? 38 : 72;
        c1t = st ? 56 : 112;
        base = l - p - 4 - msc;
        got.delete();
        exp_q.delete();
        done_seen = 1'b0;
        for (k = 0; k < c0 + l - p - 4; k++) begin
            fb = 1'(((k * pat) >> 2) ^ (k / 3));
            exp_q.push_back(fb);
            if (k < c0) c2[k] = fb;
            else u[k - c0] = fb;
        end
        r = 7'h00;
        op = 1'b0;
        for (k = msc - 1; k >= 0; k--) begin
            fb = u[base + k] ^ (st ? r[3] : r[6]);
            r = ((r << 1) & (st ? 7'h0F : 7'h7F)) ^ (fb ? (st ? 7'h03 : 7'h09) : 7'h00);
            op = op ^ u[base + k];
        end
        for (k = 0; k < p; k++) u[l - p - 4 + k] = (k == 7) ? ^{op, r} : r[k];
        if (bad >= 0) u[l - p - 4 + bad] = ~u[l - p - 4 + bad];
        for (k = l - 4; k < l; k++) u[k] = 1'b0;
        s = 4'h0;
        for (k = 0; k < l; k++) begin
            v[3 * k] = u[k] ^ s[0] ^ s[1] ^ s[2] ^ s[3];
            v[3 * k + 1] = u[k] ^ s[0] ^ s[2] ^ s[3];
            v[3 * k + 2] = u[k] ^ s[1] ^ s[3];
            s = {s[2:0], u[k]};
        end
        j = c0;
        for (k = 0; k < 3 * l; k++) begin
            i = (k < 3 * c1t) ? k % 6 : (k - 3 * c1t) % (st ? 24 : 12);
            msk = (k < 3 * c1t) ? 24'h00000B : (st ? 24'h6DB6DF : 24'h0006DF);
            if (msk[i]) begin
                c2[j] = v[k];
                j++;
            end
        end
        for (k = 0; k < n; k++) begin
            if (st) tx[(STRIDE * (k + 1)) % 216] = c2[k];
            else tx[(k % 18) * 24 + k / 18] = c2[k];
        end
        if (f0 >= 0) tx[f0] = ~tx[f0];
        if (f1 >= 0) tx[f1] = ~tx[f1];
        for (k = 0; k < n; k++) begin
            @(negedge clk_in);
            if (k == gap) begin
                valid_out = 1'b0;
                repeat (3) @(negedge clk_in);
            end
            bit_out = tx[k];
            valid_out = 1'b1;
            steal_out = (k == 0) ? st : ~st;
            while (in_ready_in !== 1'b1) @(negedge clk_in);
        end
        // Keep offering changing bits for 16 cycles while the decoder is busy
        for (k = 0; k < 16; k++) begin
            @(negedge clk_in);
            bit_out = ~bit_out;
        end
        valid_out = 1'b0;
        for (k = 0; k < 6000 && done_seen !== 1'b1; k++) @(posedge clk_in);
        @(negedge clk_in);
    endtask
endmodule

/* verif/scd_tb.sv */
// Self-checking bench for the speech channel decoder
`timescale 1ns/10ps
module tb_top;
    logic clk_in;
    logic reset_in;
    logic in_bit;
    logic in_valid;
    logic in_steal;
    logic in_ready;
    logic out_bit;
    logic out_valid;
    logic out_done;
    logic out_bfi;
    int   bad_count;
    int   check_count;

    always #12.5 clk_in = ~clk_in;

    scd_decoder u_dut (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_bit_in     (in_bit),
        .in_valid_in   (in_valid),
        .in_steal_in   (in_steal),
        .in_ready_out  (in_ready),
        .out_bit_out   (out_bit),
        .out_valid_out (out_valid),
        .out_done_out  (out_done),
        .out_bfi_out   (out_bfi)
    );

    scd_peer #(.STRIDE(5)) u_peer (
        .clk_in       (clk_in),
        .in_ready_in  (in_ready),
        .out_bit_in   (out_bit),
        .out_valid_in (out_valid),
        .out_done_in  (out_done),
        .out_bfi_in   (out_bfi),
        .bit_out      (in_bit),
        .valid_out    (in_valid),
        .steal_out    (in_steal)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Compare a finished block; inv marks one output bit expected inverted
    task automatic judge(input logic ebfi, input int inv);
        int k;
        check("done seen", 32'(u_peer.done_seen), 32'h1);
        check("output count", 32'(u_peer.got.size()), 32'(u_peer.exp_q.size()));
        check("bad frame flag", 32'(u_peer.bfi_q), 32'(ebfi));
        for (k = 0; k < u_peer.exp_q.size() && k < u_peer.got.size(); k++)
            check("output bit", 32'(u_peer.got[k]), 32'(u_peer.exp_q[k] ^ (k == inv)));
    endtask

    task automatic test_reset_values();
        check("ready after reset", 32'(in_ready), 32'h1);
        check("valid after reset", 32'(out_valid), 32'h0);
        check("flag after reset", 32'(out_bfi), 32'h0);
        $display("test_reset_values finished");
    endtask

    task automatic test_normal_clean();
        u_peer.send(1'b0, 3, -1, -1, -1, -1);
        judge(1'b0, -1);
        $display("test_normal_clean finished");
    endtask

    // Class 0 error shows, class 2 error is corrected, gap mid-block
    task automatic test_normal_errors();
        u_peer.send(1'b0, 7, -1, 0, 118, 100);
        judge(1'b0, 0);
        $display("test_normal_errors finished");
    endtask

    task automatic test_normal_bad_parity();
        u_peer.send(1'b0, 5, 0, -1, -1, -1);
        judge(1'b1, -1);
        u_peer.send(1'b0, 5, 7, -1, -1, -1);
        judge(1'b1, -1);
        $display("test_normal_bad_parity finished");
    endtask

    task automatic test_steal_clean();
        u_peer.send(1'b1, 3, -1, -1, -1, -1);
        judge(1'b0, -1);
        $display("test_steal_clean finished");
    endtask

    task automatic test_steal_bad();
        u_peer.send(1'b1, 9, 2, 5, -1, 60);
        judge(1'b1, 0);
        $display("test_steal_bad finished");
    endtask

    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        $display("Watchdog expired");
        stop_test();
    end

    initial begin
        clk_in = 1'b0;
        reset_in = 1'b1;
        bad_count = 0;
        check_count = 0;
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        @(negedge clk_in);
        test_reset_values();
        test_normal_clean();
        test_normal_errors();
        test_normal_bad_parity();
        test_steal_clean();
        test_steal_bad();
        stop_test();
    end
endmodule
